/* rtl/wtc_wakeup_timer.sv */
// Notes on behaviour
// RULE1: Slow clock divided by 1,4,8,16,128,1024,8192 or 65536 per 3-bit code.
// RULE2: Prescaler write is staged; it takes effect when sleep config is written.
// RULE3: Sleep code 1 RAM, 4 crystal, 5 RAM+crystal, 11 RAM+RC; rest reserved.
// RULE4: Wake-on-timeout bit set lets a timeout wake the chip; clear blocks it.
// RULE5: Reload value is high byte in bits 15:8 and low byte in 7:0.
// RULE6: High byte is staged; the full reload value commits on low byte write.
// RULE7: Control bit 1 set starts RC oscillator trim; cleared disables it.
// RULE8: Writing 1 to control bit 0 clears timeout and cold-start flags.
// RULE9: Status bit 5 is 0 during trim and 1 once trim ends after 1 ms.
// RULE10: Status bit 4 shows crystal settled; meaningful with sleep code 4 or 5.
// RULE11: Status bit 2 records cold start until the flag reset clears it.
// RULE12: Status bit 1 latches a timeout until the flag reset clears it.
// RULE13: Counter counts down per prescaled tick, times out at zero, reloads.
`timescale 1ns/1ns
`default_nettype none

module wtc_wakeup_timer
    import wtc_pkg::*;
#(
    parameter int ADDR_WIDTH = 12,
    parameter int TRIM_CYCLES = WTC_TRIM_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic slow_crystal_oscillator,
    input wire logic slow_rc_oscillator,
    input wire logic slow_crystal_settled,
    output logic rc_oscillator_trim_enable,
    output logic [2:0] sleep_keep,
    output logic wake_request,
    output logic irq
);

    // ----------------------------------------------------------------
    // Elaboration checks.
    // ----------------------------------------------------------------
    if (ADDR_WIDTH < 12 || ADDR_WIDTH > 32) begin : g_bad_addr
        $error("ADDR_WIDTH must lie between 12 and 32.");
    end
    if (TRIM_CYCLES < 1 || TRIM_CYCLES > 1048575) begin : g_bad_trim
        $error("TRIM_CYCLES must lie between 1 and 1048575.");
    end

    // ----------------------------------------------------------------
    // Helper functions.
    // ----------------------------------------------------------------

    // Returns the last prescaler count for a divider code.
    function automatic logic [15:0] div_last(input logic [2:0] code);
        case (code)
            3'h0: div_last = 16'h0000;
            3'h1: div_last = 16'h0003;
            3'h2: div_last = 16'h0007;
            3'h3: div_last = 16'h000f;
            3'h4: div_last = 16'h007f;
            3'h5: div_last = 16'h03ff;
            3'h6: div_last = 16'h1fff;
            default: div_last = 16'hffff;
        endcase
    endfunction

    // Maps a byte address onto a register index.
    function automatic logic [9:0] addr_index(input logic [ADDR_WIDTH-1:0] addr);
        addr_index = addr[11:2];
    endfunction

    // Tells whether a register index is mapped.
    function automatic logic index_mapped(input logic [9:0] idx);
        index_mapped = (idx >= WTC_IDX_PRESCALER && idx <= WTC_IDX_STATUS)
            || idx == WTC_IDX_IRQ_STATUS || idx == WTC_IDX_IRQ_MASK;
    endfunction

    // ----------------------------------------------------------------
    // Register state.
    // ----------------------------------------------------------------
    logic [2:0] prescaler_staged_q;
    logic [2:0] prescaler_active_q;
    wtc_sleep_cfg_type sleep_cfg_q;
    logic [7:0] reload_high_staged_q;
    logic [15:0] reload_q;
    logic [1:0] control_q;
    logic timeout_flag_q;
    logic cold_start_flag_q;
    logic boot_q;
    logic [3:0] irq_status_q;
    logic [3:0] irq_mask_q;
    logic trim_done_q;
    logic [19:0] trim_cnt_q;
    logic [15:0] pre_cnt_q;
    logic [15:0] count_q;
    logic tick_q;
    logic timeout_q;

    // Bus state.
    logic aw_hold_q;
    logic w_hold_q;
    logic [9:0] aw_idx_q;
    logic [7:0] w_byte_q;
    logic w_lane_q;

    // Synchronisers: stage 1, stage 2 and an edge stage reading stage 2.
    logic xtal_s1_q, xtal_s2_q, xtal_s3_q;
    logic rc_s1_q, rc_s2_q, rc_s3_q;
    logic settled_s1_q, settled_s2_q, settled_s3_q;

    // Write strobes decoded from a completed write.
    logic wr_go;
    logic wr_ok;
    logic wr_prescaler, wr_sleep, wr_rl_high, wr_rl_low, wr_ctrl, wr_irq_st, wr_irq_mask;
    logic use_rc;
    logic slow_edge;
    logic trim_finish;
    logic flag_clear;
    logic [3:0] irq_events;
    wtc_status_type status;

    // ----------------------------------------------------------------
    // Write decode.
    // ----------------------------------------------------------------

    // A write completes when address and data are both held.
    assign wr_go = aw_hold_q && w_hold_q && !s_axi_bvalid;
    assign wr_ok = wr_go && w_lane_q;
    assign wr_prescaler = wr_ok && aw_idx_q == WTC_IDX_PRESCALER;
    assign wr_sleep = wr_ok && aw_idx_q == WTC_IDX_SLEEP_WAKE;
    assign wr_rl_high = wr_ok && aw_idx_q == WTC_IDX_RELOAD_HIGH;
    assign wr_rl_low = wr_ok && aw_idx_q == WTC_IDX_RELOAD_LOW;
    assign wr_ctrl = wr_ok && aw_idx_q == WTC_IDX_CONTROL;
    assign wr_irq_st = wr_ok && aw_idx_q == WTC_IDX_IRQ_STATUS;
    assign wr_irq_mask = wr_ok && aw_idx_q == WTC_IDX_IRQ_MASK;

    // Flag reset acts on each write of a one to the control reset bit.
    assign flag_clear = wr_ctrl && w_byte_q[WTC_CTRL_FLAG_RESET_BIT]; // see RULE8

    // ----------------------------------------------------------------
    // AXI4-Lite write channels.
    // ----------------------------------------------------------------

    // Address and data are taken independently and held until the write.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            aw_idx_q <= 10'h000;
            w_byte_q <= 8'h00;
            w_lane_q <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= WTC_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_q <= 1'b1;
                aw_idx_q <= addr_index(s_axi_awaddr);
                s_axi_awready <= 1'b0;
            end else if (!aw_hold_q && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_q <= 1'b1;
                w_byte_q <= s_axi_wdata[7:0];
                w_lane_q <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end else if (!w_hold_q && !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
            end
            if (wr_go) begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= index_mapped(aw_idx_q) ? WTC_RESP_OKAY : WTC_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite read channels.
    // ----------------------------------------------------------------

    // Status view assembled from live state.
    always_comb begin
        status = '0;
        status.rc_trim_done = trim_done_q; // see RULE9
        status.slow_crystal_settled = settled_s2_q; // see RULE10
        status.cold_start_flag = cold_start_flag_q; // see RULE11
        status.timeout_flag = timeout_flag_q; // see RULE12
    end

    // One read at a time; write-only registers read as zero.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= WTC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= index_mapped(addr_index(s_axi_araddr)) ? WTC_RESP_OKAY
                                                                 : WTC_RESP_SLVERR;
            case (addr_index(s_axi_araddr))
                WTC_IDX_SLEEP_WAKE: s_axi_rdata <= {24'h00_0000, sleep_cfg_q};
                WTC_IDX_RELOAD_LOW: s_axi_rdata <= {24'h00_0000, reload_q[7:0]};
                WTC_IDX_CONTROL: s_axi_rdata <= {30'h0000_0000, control_q};
                WTC_IDX_STATUS: s_axi_rdata <= {24'h00_0000, status};
                WTC_IDX_IRQ_STATUS: s_axi_rdata <= {28'h000_0000, irq_status_q};
                WTC_IDX_IRQ_MASK: s_axi_rdata <= {28'h000_0000, irq_mask_q};
                default: s_axi_rdata <= 32'h0000_0000;
            endcase
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Configuration registers.
    // ----------------------------------------------------------------

    // Prescaler is staged and applied by the sleep configuration write.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prescaler_staged_q <= 3'h0;
            prescaler_active_q <= 3'h0;
            sleep_cfg_q <= '0;
        end else begin
            if (wr_prescaler) begin
                prescaler_staged_q <= w_byte_q[2:0]; // see RULE2
            end
            if (wr_sleep) begin
                sleep_cfg_q <= w_byte_q & 8'h79;
                prescaler_active_q <= prescaler_staged_q; // see RULE2
            end
        end
    end

    // Reload high byte is staged; the low byte write commits both.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            reload_high_staged_q <= WTC_RESET_BYTE;
            reload_q <= 16'h0000;
        end else begin
            if (wr_rl_high) begin
                reload_high_staged_q <= w_byte_q; // see RULE6
            end
            if (wr_rl_low) begin
                reload_q <= {reload_high_staged_q, w_byte_q}; // see RULE5 see RULE6
            end
        end
    end

    // Control register holds trim enable and the flag reset bit.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            control_q <= 2'h0;
        end else if (wr_ctrl) begin
            control_q <= w_byte_q[1:0];
        end
    end

    // ----------------------------------------------------------------
    // Input synchronisers.
    // ----------------------------------------------------------------

    // Oscillator inputs and the settled level pass two flops first.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {xtal_s1_q, xtal_s2_q, xtal_s3_q} <= 3'h0;
            {rc_s1_q, rc_s2_q, rc_s3_q} <= 3'h0;
            {settled_s1_q, settled_s2_q, settled_s3_q} <= 3'h0;
        end else begin
            {xtal_s1_q, xtal_s2_q, xtal_s3_q} <= {slow_crystal_oscillator, xtal_s1_q, xtal_s2_q};
            {rc_s1_q, rc_s2_q, rc_s3_q} <= {slow_rc_oscillator, rc_s1_q, rc_s2_q};
            {settled_s1_q, settled_s2_q, settled_s3_q} <=
                {slow_crystal_settled, settled_s1_q, settled_s2_q};
        end
    end

    // The RC oscillator drives the timer only in the RAM plus RC mode.
    assign use_rc = sleep_cfg_q.sleep_code == WTC_SLEEP_KEEP_RAM_RC;
    assign slow_edge = use_rc ? (rc_s2_q && !rc_s3_q) : (xtal_s2_q && !xtal_s3_q);

    // ----------------------------------------------------------------
    // Prescaler and countdown.
    // ----------------------------------------------------------------

    // Prescaler emits one tick per selected number of slow edges.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pre_cnt_q <= 16'h0000;
            tick_q <= 1'b0;
        end else begin
            tick_q <= 1'b0;
            if (wr_sleep) begin
                pre_cnt_q <= 16'h0000;
            end else if (slow_edge) begin
                if (pre_cnt_q >= div_last(prescaler_active_q)) begin // see RULE1
                    pre_cnt_q <= 16'h0000;
                    tick_q <= 1'b1;
                end else begin
                    pre_cnt_q <= pre_cnt_q + 16'h0001;
                end
            end
        end
    end

    // Counter reloads on commit, counts down and flags zero.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_q <= 16'h0000;
            timeout_q <= 1'b0;
        end else begin
            timeout_q <= 1'b0;
            if (wr_rl_low) begin
                count_q <= {reload_high_staged_q, w_byte_q};
            end else if (tick_q) begin
                if (count_q == 16'h0000) begin
                    timeout_q <= 1'b1; // see RULE13
                    count_q <= reload_q;
                end else begin
                    count_q <= count_q - 16'h0001; // see RULE13
                end
            end
        end
    end

    // Wake request pulses on timeout only when wake-on-timeout is set.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wake_request <= 1'b0;
        end else begin
            wake_request <= timeout_q && sleep_cfg_q.wake_on_timeout; // see RULE4
        end
    end

    // Sleep code decoded into domains to keep powered; reserved keeps none.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sleep_keep <= 3'h0;
        end else begin
            case (sleep_cfg_q.sleep_code) // see RULE3
                WTC_SLEEP_KEEP_RAM: sleep_keep <= 3'b100;
                WTC_SLEEP_KEEP_CRYSTAL: sleep_keep <= 3'b010;
                WTC_SLEEP_KEEP_RAM_CRYSTAL: sleep_keep <= 3'b110;
                WTC_SLEEP_KEEP_RAM_RC: sleep_keep <= 3'b101;
                default: sleep_keep <= 3'b000;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // RC oscillator trim.
    // ----------------------------------------------------------------
    assign trim_finish = control_q[WTC_CTRL_TRIM_EN_BIT] && !trim_done_q
        && trim_cnt_q == 20'(TRIM_CYCLES - 1);

    // Trim runs while enabled and reports done after the trim time.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trim_cnt_q <= 20'h00000;
            trim_done_q <= 1'b0;
            rc_oscillator_trim_enable <= 1'b0;
        end else begin
            rc_oscillator_trim_enable <= control_q[WTC_CTRL_TRIM_EN_BIT]; // see RULE7
            if (!control_q[WTC_CTRL_TRIM_EN_BIT]) begin
                trim_cnt_q <= 20'h00000; // see RULE7
                trim_done_q <= 1'b0;
            end else if (trim_finish) begin
                trim_done_q <= 1'b1; // see RULE9
            end else if (!trim_done_q) begin
                trim_cnt_q <= trim_cnt_q + 20'h00001;
            end
        end
    end

    // ----------------------------------------------------------------
    // Status flags.
    // ----------------------------------------------------------------

    // Cold-start and timeout latches; a set in the clear cycle wins.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            boot_q <= 1'b1;
            cold_start_flag_q <= 1'b0;
            timeout_flag_q <= 1'b0;
        end else begin
            boot_q <= 1'b0;
            if (boot_q) begin
                cold_start_flag_q <= 1'b1; // see RULE11
            end else if (flag_clear) begin
                cold_start_flag_q <= 1'b0; // see RULE8
            end
            if (timeout_q) begin
                timeout_flag_q <= 1'b1; // see RULE12
            end else if (flag_clear) begin
                timeout_flag_q <= 1'b0; // see RULE8
            end
        end
    end

    // ----------------------------------------------------------------
    // Interrupts.
    // ----------------------------------------------------------------
    assign irq_events[WTC_IRQ_TIMEOUT] = timeout_q;
    assign irq_events[WTC_IRQ_TRIM_DONE] = trim_finish;
    assign irq_events[WTC_IRQ_XTAL_SETTLED] = settled_s2_q && !settled_s3_q;
    assign irq_events[WTC_IRQ_COLD_START] = boot_q;

    // Sticky event bits, cleared by writing ones; new events win.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status_q <= WTC_IRQ_RESET;
            irq_mask_q <= WTC_IRQ_RESET;
        end else begin
            irq_status_q <= (irq_status_q & ~(wr_irq_st ? w_byte_q[3:0] : 4'h0)) | irq_events;
            if (wr_irq_mask) begin
                irq_mask_q <= w_byte_q[3:0];
            end
        end
    end

    // Interrupt line high while any unmasked event bit is set.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status_q & irq_mask_q);
        end
    end

endmodule // wtc_wakeup_timer

`default_nettype wire

/* rtl/wtc_pkg.sv */
package wtc_pkg;

    // ----------------------------------------------------------------
    // Register indices; the byte address is four times the index.
    // ----------------------------------------------------------------
    localparam logic [9:0] WTC_IDX_PRESCALER = 10'h316;
    localparam logic [9:0] WTC_IDX_SLEEP_WAKE = 10'h317;
    localparam logic [9:0] WTC_IDX_RELOAD_HIGH = 10'h318;
    localparam logic [9:0] WTC_IDX_RELOAD_LOW = 10'h319;
    localparam logic [9:0] WTC_IDX_CONTROL = 10'h31a;
    localparam logic [9:0] WTC_IDX_STATUS = 10'h31b;
    localparam logic [9:0] WTC_IDX_IRQ_STATUS = 10'h3f0;
    localparam logic [9:0] WTC_IDX_IRQ_MASK = 10'h3f1;

    // ----------------------------------------------------------------
    // Field positions and reset values.
    // ----------------------------------------------------------------
    localparam int WTC_CTRL_FLAG_RESET_BIT = 0;
    localparam int WTC_CTRL_TRIM_EN_BIT = 1;
    localparam logic [7:0] WTC_RESET_BYTE = 8'h00;
    localparam logic [3:0] WTC_IRQ_RESET = 4'h0;
    localparam int WTC_IRQ_TIMEOUT = 0;
    localparam int WTC_IRQ_TRIM_DONE = 1;
    localparam int WTC_IRQ_XTAL_SETTLED = 2;
    localparam int WTC_IRQ_COLD_START = 3;

    // ----------------------------------------------------------------
    // Sleep configuration codes.
    // ----------------------------------------------------------------
    localparam logic [3:0] WTC_SLEEP_KEEP_RAM = 4'h1;
    localparam logic [3:0] WTC_SLEEP_KEEP_CRYSTAL = 4'h4;
    localparam logic [3:0] WTC_SLEEP_KEEP_RAM_CRYSTAL = 4'h5;
    localparam logic [3:0] WTC_SLEEP_KEEP_RAM_RC = 4'hb;

    // ----------------------------------------------------------------
    // Timing: clock period and oscillator trim duration.
    // ----------------------------------------------------------------
    localparam int WTC_CLK_PERIOD_NS = 10;
    localparam int WTC_TRIM_TIME_NS = 1000000;
    localparam int WTC_TRIM_CYCLES = WTC_TRIM_TIME_NS / WTC_CLK_PERIOD_NS;

    // ----------------------------------------------------------------
    // Bus response codes.
    // ----------------------------------------------------------------
    localparam logic [1:0] WTC_RESP_OKAY = 2'b00;
    localparam logic [1:0] WTC_RESP_SLVERR = 2'b10;

    // Sleep and wake configuration register layout.
    typedef struct packed {
        logic reserved_hi;
        logic [3:0] sleep_code;
        logic [1:0] reserved_lo;
        logic wake_on_timeout;
    } wtc_sleep_cfg_type;

    // Oscillator and wake status register layout.
    typedef struct packed {
        logic [1:0] reserved_hi;
        logic rc_trim_done;
        logic slow_crystal_settled;
        logic reserved_mid;
        logic cold_start_flag;
        logic timeout_flag;
        logic reserved_lo;
    } wtc_status_type;

    // Decoded sleep domain keep flags.
    typedef struct packed {
        logic keep_ram;
        logic keep_crystal;
        logic keep_rc;
    } wtc_sleep_keep_type;

endpackage

/* verification/wtc_checker.sv */
`timescale 1ns/1ns
`default_nettype none
module wtc_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [2:0] sleep_keep,
    input wire logic wake_request,
    input wire logic irq
);
    // ----------------------------------------
    // Bus and output properties.
    // ----------------------------------------
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped early");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
        else $error("rdata changed early");
    read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("arready during read");
    write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("awready during write");
    rdata_pad_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("rdata upper bits set");
    read_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("rvalid stuck");
    wake_pulse_a: assert property ($rose(wake_request) |=> !wake_request)
        else $error("wake pulse too long");
    keep_code_a: assert property (!(sleep_keep inside {3'h1, 3'h3, 3'h7}))
        else $error("bad keep flags");
    cover property (wake_request);
    cover property (s_axi_bvalid && s_axi_bready);
    cover property (irq);
endmodule // wtc_checker
bind wtc_wakeup_timer wtc_checker u_chk (.*);
`default_nettype wire

/* verification/wtc_wakeup_timer_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module wtc_wakeup_timer_tb_top;
    import wtc_pkg::*;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, irq, wake_request, woke, rc_oscillator_trim_enable;
    logic slow_crystal_oscillator, slow_rc_oscillator, slow_crystal_settled;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [2:0] s_axi_awprot, s_axi_arprot, sleep_keep;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rp, bp;
    int failures, check_count, n, r;
    wtc_wakeup_timer #(.TRIM_CYCLES(20)) DUT (.*);
    // ----------------------------------------
    // Clock, wake capture, tasks.
    // ----------------------------------------
    // Free-running 100 MHz clock.
    initial begin
        aclk = 0;
        forever #5 aclk = ~aclk;
    end
    // Latches any wake pulse seen during a count.
    always @(posedge aclk) if (wake_request) woke <= 1;
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [9:0] i, input logic [7:0] d);
        s_axi_awaddr <= {i, 2'b00};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        forever begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_bvalid) begin
                bp = s_axi_bresp;
                break;
            end
        end
    endtask
    task rdr(input logic [9:0] i);
        s_axi_araddr <= {i, 2'b00};
        s_axi_arvalid <= 1;
        forever begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
            if (s_axi_rvalid) begin
                rd = s_axi_rdata;
                rp = s_axi_rresp;
                break;
            end
        end
    endtask
    // Counts slow crystal edges until a wake pulse, at most 40.
    task cnt;
        n = 0;
        woke = 0;
        while (!woke && n < 40) begin
            slow_crystal_oscillator <= 1;
            repeat (8) @(posedge aclk);
            slow_crystal_oscillator <= 0;
            repeat (8) @(posedge aclk);
            n++;
        end
    endtask
    task end_sim;
        $display("failures=%0d checks=%0d", failures, check_count);
        if (failures == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Watchdog against a hung handshake.
    initial begin
        #300000;
        failures++;
        end_sim;
    end
    // Main sequence.
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, woke} = 0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awprot, s_axi_arprot} = 0;
        {slow_crystal_oscillator, slow_rc_oscillator, slow_crystal_settled} = 0;
        {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3f;
        r = $urandom(32'h86a4bc9b);
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        repeat (3) @(posedge aclk);
        rdr(WTC_IDX_STATUS); chk(rd, 32'h04);
        rdr(WTC_IDX_IRQ_STATUS); chk(rd, 32'h08);
        wr(WTC_IDX_IRQ_MASK, 8'h08); repeat (2) @(posedge aclk); chk(irq, 1);
        wr(WTC_IDX_IRQ_STATUS, 8'h08); repeat (2) @(posedge aclk); chk(irq, 0);
        wr(WTC_IDX_CONTROL, 8'h01); rdr(WTC_IDX_STATUS); chk(rd, 32'h0);
        rdr(10'h100); chk(rp, WTC_RESP_SLVERR);
        wr(10'h100, 8'h5a); chk(bp, WTC_RESP_SLVERR);
        wr(WTC_IDX_IRQ_MASK, 8'h00); chk(bp, WTC_RESP_OKAY);
        for (int c = 0; c < 16; c++) begin
            wr(WTC_IDX_SLEEP_WAKE, 8'(c << 3));
            @(posedge aclk);
            chk(sleep_keep, c == 1 ? 4 : c == 4 ? 2 : c == 5 ? 6 : c == 11 ? 5 : 0);
        end
        r = $urandom % 4;
        wr(WTC_IDX_PRESCALER, 8'h01);
        wr(WTC_IDX_SLEEP_WAKE, 8'h29);
        wr(WTC_IDX_RELOAD_HIGH, 8'h00);
        wr(WTC_IDX_RELOAD_LOW, 8'(r));
        slow_crystal_settled <= 1;
        cnt; chk(n, (r + 1) * 4);
        rdr(WTC_IDX_STATUS); chk(rd, 32'h12);
        rdr(WTC_IDX_IRQ_STATUS); chk(rd, 32'h05);
        wr(WTC_IDX_PRESCALER, 8'h00);
        cnt; chk(n, (r + 1) * 4);
        wr(WTC_IDX_SLEEP_WAKE, 8'h29);
        cnt; chk(n, r + 1);
        wr(WTC_IDX_SLEEP_WAKE, 8'h28);
        cnt; chk(woke, 0);
        wr(WTC_IDX_CONTROL, 8'h02); rdr(WTC_IDX_STATUS); chk(rd[5], 0);
        repeat (25) @(posedge aclk);
        rdr(WTC_IDX_STATUS); chk(rd[5], 1);
        chk(rc_oscillator_trim_enable, 1);
        wr(WTC_IDX_CONTROL, 8'h00); rdr(WTC_IDX_STATUS); chk(rd[5], 0);
        end_sim;
    end
endmodule // wtc_wakeup_timer_tb_top
`default_nettype wire
